// >>> rtl/arr_adc_result_readout.sv
/*
 * Result holding and readout of the converter, as an AHB-Lite slave.
 * Holds the upper eight result bits, latches the two low bits on each
 * read of the upper register, and offers a start/busy control register.
 * Assumes one AHB master, single word transfers, and an asynchronous
 * comparator output pin that must be synchronised.
 */
`default_nettype none
module arr_adc_result_readout
    import arr_pkg::*;
(
    input  wire logic                  hclk,        // System clock, 200 MHz.
    input  wire logic                  hresetn,     // Asynchronous reset, active low.
    input  wire logic                  hsel,        // Slave select.
    input  wire logic [ARR_AW-1:0]     haddr,       // Byte address.
    input  wire logic [1:0]            htrans,      // Transfer type.
    input  wire logic                  hwrite,      // Write when high.
    input  wire logic [2:0]            hsize,       // Transfer size.
    input  wire logic [31:0]           hwdata,      // Write data.
    input  wire logic                  hready,      // Bus ready in.
    output logic                       hreadyout,   // Slave ready.
    output logic                       hresp,       // Always OKAY.
    output logic [31:0]                hrdata,      // Read data.
    input  wire logic                  cmp_above,   // Comparator pin, asynchronous.
    output logic [ARR_RES_W-1:0]       dac_code,    // Trial code to the DAC.
    output logic [ARR_CHAN_W-1:0]      analog_input_channel // Selected input.
);
    // Byte address of a register from its printed index.
    function automatic logic [ARR_AW-1:0] arr_addr(input logic [11:0] idx);
        arr_addr = {idx, 2'b00};
    endfunction

    logic                   cmp_s;                   // Synchronised comparator.
    logic                   eng_busy;                // Engine running.
    logic                   eng_done;                // Engine completion pulse.
    logic [ARR_RES_W-1:0]   eng_res;                 // Engine result.
    logic                   start_p;                 // Start pulse to the engine.

    // Address phase capture.
    logic                   ph_rd_r, ph_rd_nxt;      // Pending read data phase.
    logic                   ph_wr_r, ph_wr_nxt;      // Pending write data phase.
    logic [ARR_AW-1:0]      ph_a_r, ph_a_nxt;        // Pending address.
    logic [31:0]            rdata_r, rdata_nxt;      // Registered read data.

    // Result state.
    logic [7:0]             upper_r, upper_nxt;      // result_upper_byte.
    logic [1:0]             lowsh_r, lowsh_nxt;      // Low bits of latest conversion.
    logic [1:0]             lower_r, lower_nxt;      // result_lower_pair as latched.
    logic                   valid_r, valid_nxt;      // A conversion has completed.
    logic [ARR_CHAN_W-1:0]  chan_r, chan_nxt;        // Channel select.
    logic                   start_r, start_nxt;      // Start request pulse.

    logic                   acc;                     // Valid address phase.
    logic                   rd_upper;                // Upper register read this phase.

    arr_sync2 u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       (cmp_above),
        .q       (cmp_s)
    );

    arr_sar_engine u_eng (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .start     (start_p),
        .cmp_above (cmp_s),
        .trial     (dac_code),
        .busy      (eng_busy),
        .done      (eng_done),
        .result    (eng_res)
    );

    assign start_p              = start_r;
    assign hreadyout            = 1'b1;
    assign hresp                = 1'b0;
    assign hrdata               = rdata_r;
    assign analog_input_channel = chan_r;

    assign acc      = hsel && hready && (htrans == ARR_HTRANS_NSEQ || htrans == ARR_HTRANS_SEQ);
    assign rd_upper = acc && !hwrite && (haddr == arr_addr(ARR_IDX_UPPER));

    // Bus and result update. Read data is formed in the address phase
    // from the current registers, so a same-cycle completion is seen
    // only after the read.
    always_comb begin
        ph_rd_nxt = acc && !hwrite;
        ph_wr_nxt = acc && hwrite;
        ph_a_nxt  = haddr;
        rdata_nxt = rdata_r;
        upper_nxt = upper_r;
        lowsh_nxt = lowsh_r;
        lower_nxt = lower_r;
        valid_nxt = valid_r;
        chan_nxt  = chan_r;
        start_nxt = 1'b0;
        if (acc && !hwrite) begin
            rdata_nxt = 32'h0000_0000;
            if (haddr == arr_addr(ARR_IDX_UPPER)) begin
                rdata_nxt[7:0] = upper_r;                          // [R1] [R8]
            end else if (haddr == arr_addr(ARR_IDX_LOWER)) begin
                rdata_nxt[ARR_LOW_POS +: ARR_LOW_W] = lower_r;     // [R2]
            end else if (haddr == arr_addr(ARR_IDX_CTRL)) begin
                rdata_nxt[ARR_CTRL_START] = eng_busy || start_r;   // [R7]
                rdata_nxt[ARR_CTRL_DONE]  = valid_r;
                rdata_nxt[ARR_CHAN_POS +: ARR_CHAN_W] = chan_r;
            end
        end
        if (rd_upper) begin
            lower_nxt = lowsh_r;                                   // [R3] [R8]
        end
        // Writes land in the data phase; lower register is read-only so
        // the reserved zeros software sends there have no effect. [R5]
        if (ph_wr_r && ph_a_r == arr_addr(ARR_IDX_CTRL)) begin
            chan_nxt  = hwdata[ARR_CHAN_POS +: ARR_CHAN_W];
            start_nxt = hwdata[ARR_CTRL_START];                    // [R7]
        end
        if (eng_done) begin
            upper_nxt = eng_res[ARR_RES_W-1 -: 8];                 // [R1]
            lowsh_nxt = eng_res[ARR_LOW_W-1:0];                    // [R2]
            valid_nxt = 1'b1;
        end
    end

    // Register bus and result state. Low bits take a constant only to
    // keep reset clean; software must not rely on it. [R4]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_rd_r <= 1'b0;
            ph_wr_r <= 1'b0;
            ph_a_r  <= '0;
            rdata_r <= 32'h0000_0000;
            upper_r <= ARR_BYTE_ZERO;
            lowsh_r <= 2'h0;
            lower_r <= 2'h0;
            valid_r <= 1'b0;
            chan_r  <= '0;
            start_r <= 1'b0;
        end else begin
            ph_rd_r <= ph_rd_nxt;
            ph_wr_r <= ph_wr_nxt;
            ph_a_r  <= ph_a_nxt;
            rdata_r <= rdata_nxt;
            upper_r <= upper_nxt;
            lowsh_r <= lowsh_nxt;
            lower_r <= lower_nxt;
            valid_r <= valid_nxt;
            chan_r  <= chan_nxt;
            start_r <= start_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/arr_pkg.sv
/*
 * Shared constants for the converter result readout block: register
 * indices, the byte address width, field positions and reset values.
 * Assumes an AHB-Lite slave with 32-bit data and single word transfers.
 */
//Contract
//R1: Upper byte held until next conversion completes.
//R2: Two low result bits sit in bits 7:6.
//R3: Upper read latches matching low bits coherently.
//R4: Low bits need no reset value.
//R5: Software writes zero to reserved low bits.
//R6: Code equals 1024 times input over reference.
//R7: New start abandons running conversion; start reads busy.
//R8: Completion during upper read: old data first.
`default_nettype none
package arr_pkg;
    // Printed offsets are not all multiples of four, so they are indices.
    localparam logic [11:0] ARR_IDX_UPPER   = 12'hF72;   // Upper result register index.
    localparam logic [11:0] ARR_IDX_LOWER   = 12'hF73;   // Lower result register index.
    localparam logic [11:0] ARR_IDX_CTRL    = 12'hF74;   // Control and status register index.
    localparam int          ARR_AW          = 14;        // Byte address width decoded.
    localparam int          ARR_RES_W       = 10;        // Conversion result width.
    localparam int          ARR_LOW_W       = 2;         // Low result bit count.
    localparam int          ARR_LOW_POS     = 6;         // Position of low bits in lower register.
    localparam int          ARR_CTRL_START  = 0;         // Start and busy bit position.
    localparam int          ARR_CTRL_DONE   = 1;         // Result valid bit position.
    localparam int          ARR_CHAN_POS    = 4;         // Channel field position.
    localparam int          ARR_CHAN_W      = 3;         // Channel field width.
    localparam int          ARR_CONV_CYCLES = 11;        // Cycles of one conversion, one per bit plus one.
    localparam logic [7:0]  ARR_BYTE_ZERO   = 8'h00;     // Reset value of the upper byte.
    localparam logic [1:0]  ARR_HTRANS_NSEQ = 2'h2;      // AHB nonsequential transfer.
    localparam logic [1:0]  ARR_HTRANS_SEQ  = 2'h3;      // AHB sequential transfer.
endpackage
`default_nettype wire

// >>> rtl/arr_sar_engine.sv
/*
 * Successive approximation engine. Compares a trial code against the
 * sampled analog code supplied by the comparator model of the chip.
 * Assumes the comparator answer is on the same clock as hclk.
 */
`default_nettype none
module arr_sar_engine
    import arr_pkg::*;
(
    input  wire logic                 hclk,        // System clock.
    input  wire logic                 hresetn,     // Asynchronous reset, active low.
    input  wire logic                 start,       // One-cycle start pulse.
    input  wire logic                 cmp_above,   // Input at or above trial level.
    output logic [ARR_RES_W-1:0]      trial,       // Trial code driven to the DAC.
    output logic                      busy,        // Conversion running.
    output logic                      done,        // One-cycle completion pulse.
    output logic [ARR_RES_W-1:0]      result       // Completed code.
);
    // Engine states.
    typedef enum logic [0:0] {
        ARR_IDLE = 1'b0,
        ARR_CONV = 1'b1
    } arr_eng_t;

    arr_eng_t               st_r, st_nxt;          // State.
    logic [ARR_RES_W-1:0]   code_r, code_nxt;      // Accumulated code.
    logic [ARR_RES_W-1:0]   bit_r, bit_nxt;        // Bit under test, one-hot.
    logic [ARR_RES_W-1:0]   res_r, res_nxt;        // Held result.
    logic                   done_r, done_nxt;      // Done pulse.

    assign trial  = code_r | bit_r;
    assign busy   = (st_r == ARR_CONV);
    assign done   = done_r;
    assign result = res_r;

    // Next state: a start always restarts from the top bit. The binary
    // search yields code = 1024 * in / ref, saturating at 0 and all ones.
    always_comb begin
        st_nxt   = st_r;
        code_nxt = code_r;
        bit_nxt  = bit_r;
        res_nxt  = res_r;
        done_nxt = 1'b0;
        if (start) begin                                       // [R7]
            st_nxt   = ARR_CONV;
            code_nxt = '0;
            bit_nxt  = {1'b1, {(ARR_RES_W-1){1'b0}}};
        end else begin
            case (st_r)
                ARR_CONV: begin
                    if (cmp_above) begin
                        code_nxt = code_r | bit_r;             // [R6]
                    end
                    bit_nxt = bit_r >> 1;
                    if (bit_r[0]) begin
                        st_nxt   = ARR_IDLE;
                        res_nxt  = cmp_above ? (code_r | bit_r) : code_r;   // [R6]
                        done_nxt = 1'b1;
                    end
                end
                default: begin
                    st_nxt = ARR_IDLE;
                end
            endcase
        end
    end

    // Register the engine state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r   <= ARR_IDLE;
            code_r <= '0;
            bit_r  <= '0;
            res_r  <= '0;
            done_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            code_r <= code_nxt;
            bit_r  <= bit_nxt;
            res_r  <= res_nxt;
            done_r <= done_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/arr_sync2.sv
/*
 * Two flip-flop synchroniser for a single level from outside hclk.
 * Assumes the input may change at any time.
 */
`default_nettype none
module arr_sync2 (
    input  wire logic  hclk,     // System clock.
    input  wire logic  hresetn,  // Asynchronous reset, active low.
    input  wire logic  d,        // Asynchronous input.
    output logic       q         // Synchronised output.
);
    logic meta_r, meta_nxt;      // First stage, read only by the second.
    logic q_r, q_nxt;            // Second stage.

    // Shift the level through both stages.
    always_comb begin
        meta_nxt = d;
        q_nxt    = meta_r;
    end

    // Register both stages.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= 1'b0;
            q_r    <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            q_r    <= q_nxt;
        end
    end

    assign q = q_r;
endmodule
`default_nettype wire

// >>> sim/arr_adc_result_readout_chk.sv
/*
 * Checker for the converter result readout block, bound to its top module.
 * Assumes single word AHB-Lite transfers and a bus whose hready is the
 * block's own hreadyout.
 */
`default_nettype none
module arr_adc_result_readout_chk
    import arr_pkg::*;
(
    input  wire logic                  hclk,      // System clock.
    input  wire logic                  hresetn,   // Asynchronous reset, active low.
    input  wire logic                  hsel,      // Slave select.
    input  wire logic [ARR_AW-1:0]     haddr,     // Byte address.
    input  wire logic [1:0]            htrans,    // Transfer type.
    input  wire logic                  hwrite,    // Write when high.
    input  wire logic [2:0]            hsize,     // Transfer size.
    input  wire logic [31:0]           hwdata,    // Write data.
    input  wire logic                  hready,    // Bus ready.
    input  wire logic                  hreadyout, // Slave ready.
    input  wire logic                  hresp,     // Response.
    input  wire logic [31:0]           hrdata,    // Read data.
    input  wire logic                  cmp_above, // Comparator pin.
    input  wire logic [ARR_RES_W-1:0]  dac_code,  // Trial code.
    input  wire logic [ARR_CHAN_W-1:0] analog_input_channel // Selected input.
);
    localparam logic [13:0] A_UP = {ARR_IDX_UPPER, 2'b00};  // Upper register address.
    localparam logic [13:0] A_LO = {ARR_IDX_LOWER, 2'b00};  // Lower register address.
    localparam logic [13:0] A_CT = {ARR_IDX_CTRL, 2'b00};   // Control register address.
    wire logic tk = hsel && hready && htrans[1];             // Address phase taken.
    logic rd_up_r, rd_lo_r, rd_ct_r, wr_ct_r, rd_any_r;      // Data phase kinds.
    logic st_r, lo_v_r;                                      // Start pending, low copy valid.
    logic [7:0] up_r;                                        // Last upper byte read.
    logic [1:0] lo_r;                                        // Last low pair read.
    logic [4:0] cnt_r;                                       // Cycles since last start.
    // Tracks bus phases and what software last saw, so reads can be compared.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {rd_up_r, rd_lo_r, rd_ct_r, wr_ct_r, rd_any_r, st_r, lo_v_r} <= 7'h00;
            up_r  <= ARR_BYTE_ZERO;
            lo_r  <= 2'h0;
            cnt_r <= 5'h1F;
        end else if (hready) begin
            rd_up_r  <= tk && !hwrite && (haddr == A_UP);
            rd_lo_r  <= tk && !hwrite && (haddr == A_LO);
            rd_ct_r  <= tk && !hwrite && (haddr == A_CT);
            wr_ct_r  <= tk && hwrite && (haddr == A_CT);
            rd_any_r <= tk && !hwrite;
            // A start write opens a window in which the upper byte may change.
            if (wr_ct_r && hwdata[ARR_CTRL_START]) begin
                cnt_r <= 5'h00;
                st_r  <= 1'b1;
            end else if (cnt_r != 5'h1F) begin
                cnt_r <= cnt_r + 5'h01;
            end
            // An upper read refreshes the reference and voids the low copy.
            if (rd_up_r) begin
                up_r   <= hrdata[7:0];
                lo_v_r <= 1'b0;
                // Reads whose address phase follows the completion cycle see the final byte.
                if (cnt_r >= 5'd13) begin
                    st_r <= 1'b0;
                end
            end
            if (rd_lo_r) begin
                lo_r   <= hrdata[7:6];
                lo_v_r <= 1'b1;
            end
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_upper_held: assert property (rd_up_r && hready && !st_r |-> hrdata[7:0] == up_r)
        else $error("upper byte changed without a conversion");
    a_rdata_holds: assert property ($changed(hrdata) |-> rd_any_r)
        else $error("read data changed outside a read");
    a_low_field: assert property (rd_lo_r && hready |-> hrdata[5:0] == 6'h00)
        else $error("lower register bits below the low pair not zero");
    a_low_latched: assert property (rd_lo_r && hready && lo_v_r |-> hrdata[7:6] == lo_r)
        else $error("low pair changed without an upper read");
    a_busy_running: assert property (rd_ct_r && cnt_r inside {[4:9]} |-> hrdata[0])
        else $error("busy not reported during conversion");
    a_idle_later: assert property (rd_ct_r && cnt_r >= 5'd20 |-> !hrdata[0])
        else $error("busy still reported long after start");
    a_chan_follow: assert property (wr_ct_r && hready |=>
        analog_input_channel == $past(hwdata[6:4]))
        else $error("channel select does not follow control write");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");
endmodule
bind arr_adc_result_readout arr_adc_result_readout_chk u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmp_above(cmp_above),
    .dac_code(dac_code), .analog_input_channel(analog_input_channel));
`default_nettype wire

// >>> sim/arr_adc_result_readout_tb.sv
/*
 * Self-checking bench for the converter result readout block.
 * Assumes a zero wait AHB-Lite slave and a comparator held steady per
 * conversion, so each result saturates to all ones or all zeros.
 */
`default_nettype none
module arr_adc_result_readout_tb;
    import arr_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [13:0] A_UP = {ARR_IDX_UPPER, 2'b00};  // Upper register address.
    localparam logic [13:0] A_LO = {ARR_IDX_LOWER, 2'b00};  // Lower register address.
    localparam logic [13:0] A_CT = {ARR_IDX_CTRL, 2'b00};   // Control register address.
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, cmp_above = 1'b0;
    logic [13:0] haddr = 14'h0000;                           // Bus address.
    logic [1:0]  htrans = 2'h0;                              // Transfer type.
    logic [2:0]  hsize = 3'h2;                               // Always a word.
    logic [31:0] hwdata = 32'h0, hrdata, rd;                 // Bus data.
    logic        hreadyout, hresp;                           // Slave answer.
    logic [9:0]  dac_code;                                   // Trial code.
    logic [2:0]  chan;                                       // Selected input.
    int          n_errors = 0, total_checks = 0, res, lo_lat, ch, i;
    arr_adc_result_readout DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmp_above(cmp_above),
        .dac_code(dac_code), .analog_input_channel(chan));
    // Free running 200 MHz clock.
    initial forever #2.5 hclk = ~hclk;
    // Compares a value against the model and counts the outcome.
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    // Prints the verdict and ends the run.
    task automatic test_done();
        if (n_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One single AHB-Lite word transfer; entered just after a rising edge.
    task automatic ahb(input logic w, input logic [13:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= ARR_HTRANS_NSEQ;
        haddr  <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        if (w) hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    // Runs one conversion at a steady comparator level and waits until idle.
    task automatic conv(input int lvl, input int c);
        int j;
        cmp_above <= lvl[0];
        repeat (4) @(posedge hclk);
        ahb(1'b1, A_CT, (c << ARR_CHAN_POS) | 1, rd);
        for (j = 0; j < 60; j++) begin
            ahb(1'b0, A_CT, 32'h0, rd);
            if (rd[0] === 1'b0) break;
        end
        check({31'h0, rd[0]}, 32'h0, "converter still busy");
        res = lvl ? 10'h3FF : 10'h000;
    endtask
    // Watchdog against a hung bus or converter.
    initial begin
        #50us;
        n_errors++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        test_done();
    end
    initial begin
        void'($urandom(83));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, A_UP, 32'h0, rd);
        check(rd, 32'h0, "upper byte after reset");
        for (i = 0; i < 8; i++) begin
            ch = $urandom % 8;
            conv(i < 2 ? i : $urandom % 2, ch);
            check({29'h0, chan}, ch, "channel select");
            check({22'h0, dac_code}, res, "trial code at rest");
            ahb(1'b0, A_UP, 32'h0, rd);
            check(rd, res >> 2, "upper byte");
            ahb(1'b0, A_LO, 32'h0, rd);
            check(rd, (res & 3) << ARR_LOW_POS, "lower pair");
        end
        conv(1, 2);
        ahb(1'b0, A_UP, 32'h0, rd);
        lo_lat = res & 3;
        conv(0, 5);
        ahb(1'b0, A_LO, 32'h0, rd);
        check(rd, lo_lat << ARR_LOW_POS, "low pair not held from upper read");
        ahb(1'b1, A_UP, 32'hFFFF_FFFF, rd);
        ahb(1'b1, A_LO, 32'h0000_00C0, rd);
        ahb(1'b0, A_UP, 32'h0, rd);
        check(rd, 32'h0, "upper byte after new conversion");
        ahb(1'b0, A_LO, 32'h0, rd);
        check(rd, 32'h0, "lower pair after new conversion");
        // Upper read whose address phase meets the completion pulse.
        conv(1, 3);
        cmp_above <= 1'b0;
        repeat (4) @(posedge hclk);
        ahb(1'b1, A_CT, 32'h1, rd);
        repeat (ARR_CONV_CYCLES) @(posedge hclk);
        ahb(1'b0, A_UP, 32'h0, rd);
        check(rd, res >> 2, "upper byte on completing cycle");
        ahb(1'b0, A_LO, 32'h0, rd);
        check(rd, (res & 3) << ARR_LOW_POS, "low pair on completing cycle");
        ahb(1'b0, A_UP, 32'h0, rd);
        check(rd, 32'h0, "upper byte after completion");
        ahb(1'b0, A_LO, 32'h0, rd);
        check(rd, 32'h0, "low pair after completion");
        cmp_above <= 1'b1;
        repeat (4) @(posedge hclk);
        ahb(1'b1, A_CT, 32'h1, rd);
        ahb(1'b0, A_CT, 32'h0, rd);
        ahb(1'b0, A_CT, 32'h0, rd);
        check({31'h0, rd[0]}, 32'h1, "busy during conversion");
        conv(0, 7);
        ahb(1'b0, A_UP, 32'h0, rd);
        check(rd, 32'h0, "restarted conversion result");
        ahb(1'b0, 14'h0100, 32'h0, rd);
        check(rd, 32'h0, "unmapped read");
        ahb(1'b0, A_UP, 32'h0, rd);
        check(rd, 32'h0, "upper byte held without conversion");
        test_done();
    end
endmodule
`default_nettype wire
